// ===== src/ashb_regs.vh
// constants for the asynchronous handshake bus master
// assumes inclusion by bare name from files under src/
`ifndef ASHB_REGS_VH
`define ASHB_REGS_VH

// size line encodings {xfer_size_hi, xfer_size_lo}
`define ASHB_SIZE_LONG   2'h0
`define ASHB_SIZE_BYTE   2'h1
`define ASHB_SIZE_WORD   2'h2
`define ASHB_SIZE_3BYTE  2'h3

// pin widths
`define ASHB_ADDR_W      24
`define ASHB_DATA_W      16
`define ASHB_SPACE_W     3

// reset values of driven pins
`define ASHB_ADDR_RST    24'h000000
`define ASHB_DATA_RST    16'h0000
`define ASHB_SPACE_RST   3'h0
`define ASHB_SIZE_RST    2'h0

// reset value of synchronised inputs: acks, fault and data idle high
`define ASHB_IN_W        19
`define ASHB_IN_RST      19'h7FFFF

`endif

// ===== src/ashb_sync.v
// two-flop synchroniser, one chain per bit
// assumes inputs arrive asynchronously to CLK; output is stable in CLK domain
`timescale 1ns/100ps
`default_nettype none
module ashb_sync #(
	parameter WIDTH   = 1,
	parameter RST_VAL = 1'b0
) (
	// clock and reset
	input  wire             CLK,
	input  wire             SYS_RST,
	// data
	input  wire [WIDTH-1:0] D_IN,
	output wire [WIDTH-1:0] D_OUT
);
	genvar i;
	// each bit passes two flops; only the second flop is visible
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_r;
			reg sync_r;
			always @(posedge CLK) begin
				if (SYS_RST) begin
					meta_r <= RST_VAL[i];
					sync_r <= RST_VAL[i];
				end else begin
					meta_r <= D_IN[i];
					sync_r <= meta_r;
				end
			end
			assign D_OUT[i] = sync_r;
		end
	endgenerate
endmodule // ashb_sync
`default_nettype wire

// ===== src/ashb_master.v
// bus master sequencer for a nonmultiplexed 24-bit address, 16-bit data bus
// assumes one CLK period per bus state, so two CLK periods per bus clock;
// slave acks and data are asynchronous and are synchronised here
// Function
// - separate 24-bit address bus and 16-bit data bus, never multiplexed
// - register all driven pins; synchronise acks and data before use
// - word/long reads take two bytes, byte reads one; lane by size, lsb, port
// - read S0 drives address, space code, direction high, size lines
// - read S1 asserts address strobe and data strobe together
// - ack seen by end of S2 means data latched at end of S4
// - no ack at S2 sample inserts wait states, resampling every bus clock
// - read S5 negates strobes, holds address, direction, size, space code
// - write S0 drives address, space code, direction low, size lines
// - write S1 asserts only the address strobe
// - write S2 drives full data bus; acks sampled at end of S2
// - write S3 asserts data strobe; cycle ends one clock after ack (the code asserts it from W3 when waits follow S2)
// - write S4 changes nothing; S5 negates strobes, holds all else
`timescale 1ns/100ps
`default_nettype none
`include "ashb_regs.vh"
module ashb_master (
	// clock and reset
	input  wire                       CLK,
	input  wire                       SYS_RST,
	// user request
	input  wire                       REQ,
	input  wire                       REQ_WRITE,
	input  wire [`ASHB_ADDR_W-1:0]    REQ_ADDR,
	input  wire [`ASHB_SPACE_W-1:0]   REQ_SPACE,
	input  wire [1:0]                 REQ_SIZE,
	input  wire [`ASHB_DATA_W-1:0]    REQ_WDATA,
	// user answer
	output wire                       READY,
	output reg                        DONE,
	output reg                        FAULT,
	output reg                        RESP_PORT8,
	output reg  [`ASHB_DATA_W-1:0]    RDATA,
	// bus pins driven
	output reg  [`ASHB_ADDR_W-1:0]    ADDR_BUS,
	output reg  [`ASHB_SPACE_W-1:0]   SPACE_CODE,
	output reg                        XFER_SIZE_HI,
	output reg                        XFER_SIZE_LO,
	output reg                        READ_WRITE,
	output reg                        ADDRESS_STROBE_N,
	output reg                        DATA_STROBE_N,
	// two-way data bus
	input  wire [`ASHB_DATA_W-1:0]    DATA_BUS_IN,
	output reg  [`ASHB_DATA_W-1:0]    DATA_BUS_OUT,
	output reg                        DATA_BUS_OE_N,
	// slave answers
	input  wire                       PORT_ACK_HIGH_N,
	input  wire                       PORT_ACK_LOW_N,
	input  wire                       BUS_FAULT_N
);
	// one-hot bus states
	localparam [8:0] ST_IDLE = 9'h001;
	localparam [8:0] ST_S0   = 9'h002;
	localparam [8:0] ST_S1   = 9'h004;
	localparam [8:0] ST_S2   = 9'h008;
	localparam [8:0] ST_W3   = 9'h010;
	localparam [8:0] ST_W4   = 9'h020;
	localparam [8:0] ST_S3   = 9'h040;
	localparam [8:0] ST_S4   = 9'h080;
	localparam [8:0] ST_S5   = 9'h100;
	// reset code of the size lines, split per pin below
	localparam [1:0] SIZE_RST = `ASHB_SIZE_RST;

	reg  [8:0]               state_r;
	reg  [8:0]               state_nxt;
	reg                      write_r;
	reg                      fault_r;
	reg                      port8_r;
	reg  [`ASHB_DATA_W-1:0]  wdata_r;
	wire [`ASHB_IN_W-1:0]    in_sync;
	wire                     ack_hi_n_s;
	wire                     ack_lo_n_s;
	wire                     fault_n_s;
	wire [`ASHB_DATA_W-1:0]  data_s;
	wire                     sample;
	wire                     ack_seen;
	wire                     fault_seen;
	wire                     take;
	wire                     byte_op;
	reg                      as_n_nxt;
	reg                      ds_n_nxt;
	reg                      oe_n_nxt;
	reg  [`ASHB_DATA_W-1:0]  rdata_nxt;

	// slave inputs pass two flops before any logic reads them
	ashb_sync #(
		.WIDTH   (`ASHB_IN_W),
		.RST_VAL (`ASHB_IN_RST)
	) u_sync (
		.CLK     (CLK),
		.SYS_RST (SYS_RST),
		.D_IN    ({BUS_FAULT_N, PORT_ACK_HIGH_N, PORT_ACK_LOW_N, DATA_BUS_IN}),
		.D_OUT   (in_sync)
	);

	// unpack synchronised inputs
	assign fault_n_s  = in_sync[18];
	assign ack_hi_n_s = in_sync[17];
	assign ack_lo_n_s = in_sync[16];
	assign data_s     = in_sync[15:0];

	// ack sampling points are the bus clock falling edges: end of S2 and of W4
	assign sample     = (state_r == ST_S2) || (state_r == ST_W4);
	assign ack_seen   = ~ack_hi_n_s | ~ack_lo_n_s;
	assign fault_seen = ~fault_n_s;
	assign take       = REQ && (state_r == ST_IDLE);
	assign READY      = (state_r == ST_IDLE);
	assign byte_op    = ({XFER_SIZE_HI, XFER_SIZE_LO} == `ASHB_SIZE_BYTE);

	// next bus state, one step per half bus clock
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (take) state_nxt = ST_S0;
			ST_S0:   state_nxt = ST_S1;
			ST_S1:   state_nxt = ST_S2;
			ST_S2: begin
				if (ack_seen || fault_seen) state_nxt = ST_S3;
				else state_nxt = ST_W3;
			end
			ST_W3:   state_nxt = ST_W4;
			ST_W4: begin
				if (ack_seen || fault_seen) state_nxt = ST_S3;
				else state_nxt = ST_W3;
			end
			ST_S3:   state_nxt = ST_S4;
			ST_S4:   state_nxt = ST_S5;
			ST_S5:   state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// strobes and data enable follow the state being entered
	always @* begin
		as_n_nxt = 1'b1;
		ds_n_nxt = 1'b1;
		oe_n_nxt = 1'b1;
		case (state_nxt)
			ST_S1: begin
				as_n_nxt = 1'b0;
				ds_n_nxt = write_r;
			end
			ST_S2: begin
				as_n_nxt = 1'b0;
				ds_n_nxt = write_r;
				oe_n_nxt = ~write_r;
			end
			ST_W3, ST_W4, ST_S3, ST_S4: begin
				as_n_nxt = 1'b0;
				ds_n_nxt = 1'b0;
				oe_n_nxt = ~write_r;
			end
			ST_S5: begin
				as_n_nxt = 1'b1;
				ds_n_nxt = 1'b1;
				oe_n_nxt = ~write_r;
			end
			default: begin
				as_n_nxt = 1'b1;
				ds_n_nxt = 1'b1;
				oe_n_nxt = 1'b1;
			end
		endcase
	end

	// byte lane selection for read data, right-justified for byte operands
	always @* begin
		rdata_nxt = data_s;
		if (byte_op) begin
			if (port8_r || !ADDR_BUS[0]) rdata_nxt = {8'h00, data_s[15:8]};
			else rdata_nxt = {8'h00, data_s[7:0]};
		end
	end

	// sequencer and cycle bookkeeping
	always @(posedge CLK) begin
		if (SYS_RST) begin
			state_r    <= ST_IDLE;
			write_r    <= 1'b0;
			fault_r    <= 1'b0;
			port8_r    <= 1'b0;
			wdata_r    <= `ASHB_DATA_RST;
			DONE       <= 1'b0;
			FAULT      <= 1'b0;
			RESP_PORT8 <= 1'b0;
			RDATA      <= `ASHB_DATA_RST;
		end else begin
			state_r <= state_nxt;
			DONE    <= 1'b0;
			FAULT   <= 1'b0;
			if (take) begin
				write_r <= REQ_WRITE;
				fault_r <= 1'b0;
				// byte writes repeat the byte on both lanes
				if (REQ_SIZE == `ASHB_SIZE_BYTE) wdata_r <= {REQ_WDATA[7:0], REQ_WDATA[7:0]};
				else wdata_r <= REQ_WDATA;
			end
			// port width from the ack pair; only the lower line means 8 bits
			if (sample && (ack_seen || fault_seen)) begin
				fault_r <= fault_seen;
				port8_r <= ack_hi_n_s & ~ack_lo_n_s;
			end
			// read data is latched at the end of S4
			if (state_r == ST_S4 && !write_r && !fault_r) begin
				RDATA <= rdata_nxt;
			end
			// completion reported as the bus returns to idle
			if (state_r == ST_S5) begin
				DONE       <= ~fault_r;
				FAULT      <= fault_r;
				RESP_PORT8 <= port8_r;
			end
		end
	end

	// pins: address, space, size, direction are registered and held to S5
	always @(posedge CLK) begin
		if (SYS_RST) begin
			ADDR_BUS         <= `ASHB_ADDR_RST;
			SPACE_CODE       <= `ASHB_SPACE_RST;
			XFER_SIZE_HI     <= SIZE_RST[1];
			XFER_SIZE_LO     <= SIZE_RST[0];
			READ_WRITE       <= 1'b1;
			ADDRESS_STROBE_N <= 1'b1;
			DATA_STROBE_N    <= 1'b1;
			DATA_BUS_OUT     <= `ASHB_DATA_RST;
			DATA_BUS_OE_N    <= 1'b1;
		end else begin
			if (take) begin
				ADDR_BUS     <= REQ_ADDR;
				SPACE_CODE   <= REQ_SPACE;
				XFER_SIZE_HI <= REQ_SIZE[1];
				XFER_SIZE_LO <= REQ_SIZE[0];
				READ_WRITE   <= ~REQ_WRITE;
			end
			ADDRESS_STROBE_N <= as_n_nxt;
			DATA_STROBE_N    <= ds_n_nxt;
			DATA_BUS_OE_N    <= oe_n_nxt;
			if (state_nxt == ST_S2 && write_r) DATA_BUS_OUT <= wdata_r;
		end
	end
endmodule // ashb_master
`default_nettype wire

// ===== test/ashb_slave.sv
// slave device model for the bus master
// assumes one CLK domain; answers after dly+1 strobe cycles
`timescale 1ns/100ps
`default_nettype none
module ashb_slave (
	input  wire logic        clk,
	input  wire logic        as_n, ds_n, rw, byte_sz,
	input  wire logic [4:0]  addr,
	input  wire logic [15:0] wd,
	input  wire logic [1:0]  dly,
	input  wire logic        p8, flt,
	output logic [15:0]      rd,
	output logic             ack_h_n, ack_l_n, fault_n
);
	logic [15:0] mem [0:15];
	logic [2:0]  cnt = 3'h0;
	logic        hit = 1'b0;
	wire  [15:0] w = mem[addr[4:1]];
	wire  [7:0]  b = addr[0] ? w[7:0] : w[15:8];
	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
		{rd, ack_h_n, ack_l_n, fault_n} = {16'h0000, 3'h7};
	end
	// count strobe cycles, store, answer; let go once both strobes negate
	always @(posedge clk) begin
		if (as_n && ds_n) begin
			{cnt, hit, ack_h_n, ack_l_n, fault_n} <= {4'h0, 3'h7};
			rd <= ~rd;
		end else begin
			if (cnt <= {1'b0, dly}) cnt <= cnt + 3'h1;
			if (!rw && !ds_n && !hit) begin
				hit <= 1'b1;
				if (!byte_sz) mem[addr[4:1]] <= wd;
				else if (addr[0]) mem[addr[4:1]][7:0] <= wd[7:0];
				else mem[addr[4:1]][15:8] <= wd[15:8];
			end
			if (cnt > {1'b0, dly} && (rw || hit)) begin
				if (flt) fault_n <= 1'b0;
				else if (p8) ack_l_n <= 1'b0;
				else ack_h_n <= 1'b0;
				if (rw) rd <= p8 ? {b, b} : w;
			end
		end
	end
endmodule // ashb_slave
`default_nettype wire

// ===== test/ashb_master_assertions.sv
// pin sequencing checks for the bus master
// assumes bind onto ashb_master; one clock, sync reset
`timescale 1ns/100ps
`default_nettype none
module ashb_checker (
	input wire logic        CLK, SYS_RST, DONE, FAULT, READ_WRITE,
	input wire logic        ADDRESS_STROBE_N, DATA_STROBE_N, DATA_BUS_OE_N,
	input wire logic        PORT_ACK_HIGH_N, PORT_ACK_LOW_N, BUS_FAULT_N,
	input wire logic [23:0] ADDR_BUS,
	input wire logic [2:0]  SPACE_CODE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	property p_rd_s1; READ_WRITE && $fell(ADDRESS_STROBE_N) |-> !DATA_STROBE_N; endproperty
	a_rd_s1: assert property (p_rd_s1) else $error("read strobes apart");
	property p_s0; $fell(ADDRESS_STROBE_N) |-> $stable(ADDR_BUS) && $stable(READ_WRITE); endproperty
	a_s0: assert property (p_s0) else $error("address late");
	property p_wr_s1; !READ_WRITE && $fell(ADDRESS_STROBE_N) |-> DATA_STROBE_N; endproperty
	a_wr_s1: assert property (p_wr_s1) else $error("write data strobe early");
	property p_wr_s2; !READ_WRITE && $fell(ADDRESS_STROBE_N) |=> !DATA_BUS_OE_N; endproperty
	a_wr_s2: assert property (p_wr_s2) else $error("write data not driven");
	property p_wr_s3; !READ_WRITE && $fell(ADDRESS_STROBE_N) |-> ##2 $fell(DATA_STROBE_N); endproperty
	a_wr_s3: assert property (p_wr_s3) else $error("write data strobe off");
	property p_s4; !READ_WRITE && $fell(DATA_STROBE_N) |=> $stable(ADDRESS_STROBE_N)
		&& $stable(DATA_BUS_OE_N) && !DATA_STROBE_N; endproperty
	a_s4: assert property (p_s4) else $error("control moved in S4");
	property p_s5; $rose(ADDRESS_STROBE_N) |-> DATA_STROBE_N && $stable(ADDR_BUS)
		&& $stable(READ_WRITE) && $stable(SPACE_CODE); endproperty
	a_s5: assert property (p_s5) else $error("S5 hold broken");
	property p_end; $rose(ADDRESS_STROBE_N) |=> DONE || FAULT; endproperty
	a_end: assert property (p_end) else $error("no completion");
	property p_wait; (!ADDRESS_STROBE_N && PORT_ACK_HIGH_N && PORT_ACK_LOW_N
		&& BUS_FAULT_N) [*3] |=> !ADDRESS_STROBE_N; endproperty
	a_wait: assert property (p_wait) else $error("ended without ack");
	c_rd: cover property (READ_WRITE && DONE);
	c_wr: cover property (!READ_WRITE && DONE);
	c_flt: cover property (FAULT);
endmodule // ashb_checker
bind ashb_master ashb_checker i_ashb_checker (.CLK, .SYS_RST, .DONE, .FAULT, .READ_WRITE,
	.ADDRESS_STROBE_N, .DATA_STROBE_N, .DATA_BUS_OE_N, .PORT_ACK_HIGH_N,
	.PORT_ACK_LOW_N, .BUS_FAULT_N, .ADDR_BUS, .SPACE_CODE);
`default_nettype wire

// ===== test/ashb_master_tb.sv
// self-checking bench: bus master against a slave model
// assumes ashb_regs.vh on the include path
`timescale 1ns/100ps
`default_nettype none
`include "ashb_regs.vh"
module ashb_master_tb;
	logic CLK = 0, SYS_RST = 1, REQ = 0, REQ_WRITE = 0, p8 = 0, flt = 0;
	logic w, bs, s8, f, b2, lastx = 1;
	logic [23:0] REQ_ADDR = 24'h000000;
	logic [2:0] REQ_SPACE = 3'h0;
	logic [1:0] REQ_SIZE = 2'h2, dly = 2'h0, dl = 2'h0;
	logic [15:0] REQ_WDATA = 16'h0000, sh [0:15], sd;
	logic [31:0] seed = 32'd70, r, r2;
	logic [48:0] q [$], x;
	int error_cnt = 0, checked = 0;
	wire READY, DONE, FAULT, RESP_PORT8, XFER_SIZE_HI, XFER_SIZE_LO, READ_WRITE;
	wire ADDRESS_STROBE_N, DATA_STROBE_N, DATA_BUS_OE_N;
	wire PORT_ACK_HIGH_N, PORT_ACK_LOW_N, BUS_FAULT_N;
	wire [15:0] RDATA, DATA_BUS_OUT;
	wire [23:0] ADDR_BUS;
	wire [2:0] SPACE_CODE;
	// data bus level: master while it drives, else the slave
	wire [15:0] DATA_BUS_IN = DATA_BUS_OE_N ? sd : DATA_BUS_OUT;
	ashb_master i_ashb_master (.CLK, .SYS_RST, .REQ, .REQ_WRITE, .REQ_ADDR, .REQ_SPACE,
		.REQ_SIZE, .REQ_WDATA, .READY, .DONE, .FAULT, .RESP_PORT8, .RDATA, .ADDR_BUS,
		.SPACE_CODE, .XFER_SIZE_HI, .XFER_SIZE_LO, .READ_WRITE, .ADDRESS_STROBE_N,
		.DATA_STROBE_N, .DATA_BUS_IN, .DATA_BUS_OUT, .DATA_BUS_OE_N, .PORT_ACK_HIGH_N,
		.PORT_ACK_LOW_N, .BUS_FAULT_N);
	ashb_slave i_ashb_slave (.clk(CLK), .as_n(ADDRESS_STROBE_N), .ds_n(DATA_STROBE_N),
		.rw(READ_WRITE), .byte_sz(XFER_SIZE_LO), .addr(ADDR_BUS[4:0]), .wd(DATA_BUS_IN),
		.dly, .p8, .flt, .rd(sd), .ack_h_n(PORT_ACK_HIGH_N), .ack_l_n(PORT_ACK_LOW_N),
		.fault_n(BUS_FAULT_N));
	initial forever #4 CLK = ~CLK;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string n, input logic [23:0] s, e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report();
		if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one request; b2b presents it while the previous one runs
	task automatic issue(input logic b, input logic [23:0] a, input logic [15:0] d,
		input logic [2:0] sp);
		logic [15:0] e;
		e = sh[a[4:1]];
		if (bs) e = {8'h00, a[0] ? e[7:0] : e[15:8]};
		if (!b) begin
			REQ <= 1'b0;
			do @(negedge CLK); while (READY !== 1'b1);
			@(posedge CLK);
		end
		{REQ, REQ_WRITE, REQ_ADDR, REQ_SPACE, REQ_WDATA} <= {1'b1, w, a, sp, d};
		REQ_SIZE <= bs ? `ASHB_SIZE_BYTE : `ASHB_SIZE_WORD;
		{dly, p8, flt} <= {dl, s8, f};
		do @(negedge CLK); while (READY !== 1'b1);
		@(posedge CLK);
		q.push_back({f, !w && !f, s8, !w, bs ? 2'h1 : 2'h2, sp, a, e});
		if (w && !bs) sh[a[4:1]] = d;
		else if (w && a[0]) sh[a[4:1]][7:0] = d[7:0];
		else if (w) sh[a[4:1]][15:8] = d[7:0];
	endtask
	// completion watcher takes the oldest note
	initial forever begin
		@(negedge CLK);
		if (DONE === 1'b1 || FAULT === 1'b1) begin
			if (q.size() == 0) chk("spare", 1, 0);
			else begin
				x = q.pop_front();
				chk("fault", FAULT, x[48]);
				chk("ready", READY, 24'h000001);
				chk("addr", ADDR_BUS, x[39:16]);
				chk("ctl", {READ_WRITE, XFER_SIZE_HI, XFER_SIZE_LO, SPACE_CODE}, x[45:40]);
				if (x[47]) chk("rdata", RDATA, x[15:0]);
				if (x[47]) chk("port8", RESP_PORT8, x[46]);
			end
		end
	end
	initial begin
		#100000;
		error_cnt++;
		final_report();
	end
	// random reads and writes, byte and word, waits, 8-bit port, faults
	initial begin
		for (int i = 0; i < 16; i++) sh[i] = 16'h0000;
		repeat (12) @(posedge CLK);
		SYS_RST <= 1'b0;
		for (int i = 0; i < 80; i++) begin
			r = rnd();
			r2 = rnd();
			f = (i % 11 == 7);
			w = r[0] && !f;
			bs = r[1];
			s8 = r[2] && bs && !w;
			b2 = r[3] && !s8 && !f && !lastx;
			if (!b2) dl = r[5:4];
			lastx = s8 || f;
			issue(b2, {r[31:13], r[10:7], bs & r[6]}, r2[15:0], r2[18:16]);
		end
		REQ <= 1'b0;
		repeat (30) @(posedge CLK);
		chk("left", 24'(q.size()), 24'h000000);
		final_report();
	end
endmodule // ashb_master_tb
`default_nettype wire
